// ### inc/ctrl_port_pkg.sv
// Shared constants and types for the codec control port and its host.
// Assumes a 40 MHz system clock on both ends of the link.
package ctrl_port_pkg;

	// Clock and serial timing.
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned I2C_BIT_NS    = 10000;
	// Quarter of a bit is a least time, so it rounds up.
	localparam int unsigned QUARTER_CYC   = (I2C_BIT_NS + 4 * CLK_PERIOD_NS - 1)
	                                        / (4 * CLK_PERIOD_NS);

	// Chip address layout.
	localparam logic [4:0] CHIP_ADDR_HI  = 5'h13;
	localparam logic       CHIP_ADDR_A1  = 1'h0;
	localparam logic [6:0] SPI_CHIP_ADDR = 7'h4F;
	localparam logic [3:0] BYTE_LAST_BIT = 4'h8;

	// Device transfer states.
	typedef enum {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
		ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
	} dev_state_t;

	// Host bus operations.
	typedef enum {OP_START, OP_TX, OP_RX, OP_STOP, OP_END} host_op_t;

endpackage : ctrl_port_pkg

// ### inc/ctrl_link_if.sv
// Two-wire / serial-peripheral link between the host and the codec port.
// Assumes a pull-up on the data line; either party may only pull it low.
`timescale 1ns/100ps
`default_nettype none
interface ctrl_link_if;
	logic scl;            // Serial clock, made by the host.
	logic cs_strap;       // Strap level, or active-low select.
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic sda;            // Resolved data line.

	// Open-drain data line with a pull-up.
	assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

	modport host (output scl, output cs_strap, output host_sda_out,
	              output host_sda_oe_n, input sda);
	modport device (input scl, input cs_strap, output dev_sda_out,
	                output dev_sda_oe_n, input sda);
endinterface : ctrl_link_if
`default_nettype wire

// ### src/codec_control_port.sv
// Codec control port: two-wire slave plus serial-peripheral write path.
// Assumes the register file answers reg_rdata combinationally from reg_addr
// on clk, and that the link pins are asynchronous to clk.
//
// Functional notes
// R1: Data falling with clock high starts transfer.
// R2: Data rising with clock high stops transfer.
// R3: Host sends chip address plus direction bit.
// R4: Match address 10011, strap bit as LSB.
// R5: Strap pin level latched during reset.
// R6: First write byte loads register pointer.
// R7: Reads return pointed register, never set pointer.
// R8: Step flag set gives consecutive register access.
// R9: Pointer MSB is step flag; clear holds.
// R10: Acknowledge after every byte, both directions.
// R11: Host sets pointer by write, stop, read.
// R12: Stop after pointer leaves registers untouched.
// R13: Port timing independent of audio clocks.
// R14: Host keeps bus quiet when idle.
// R15: First strap pin fall selects serial-peripheral mode.
// R16: Serial-peripheral data sampled on clock rise.
// R17: Host frames serial accesses with select low.
// R18: Serial first byte 10011110 write, 10011111 read; here 10011111 is not matched and the frame is ignored.
// R19: Unmatched address: no acknowledge, ignore until start.
`timescale 1ns/100ps
`default_nettype none
module codec_control_port (
	input  wire logic       clk,
	input  wire logic       nrst,
	ctrl_link_if.device     link,
	input  wire logic [7:0] reg_rdata,
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_we,
	output logic            spi_mode,
	output logic            strap
);

	ctrl_port_pkg::dev_state_t state;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic       scl_p;
	logic       sda_p;
	logic       cs_p;
	logic       tgl_p;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic       rw;
	logic       host_ack;
	logic       step_flag;
	logic [1:0] spi_idx;
	logic [2:0] spi_cnt;
	logic [7:0] spi_sh;
	logic [7:0] spi_byte;
	logic       spi_tgl;

	// Serial-peripheral shift side runs on the link clock; bit count is
	// cleared by select so each frame starts byte-aligned.
	always_ff @(posedge link.scl or posedge link.cs_strap) begin
		if (link.cs_strap) begin
			spi_cnt <= 3'h0;
		end else begin
			spi_cnt <= spi_cnt + 3'h1;
		end
	end

	// Bits are taken on the rising link clock edge. R16
	always_ff @(posedge link.scl) begin
		spi_sh <= {spi_sh[6:0], link.sda}; // R16
		if (spi_cnt == 3'h7) begin
			spi_byte <= {spi_sh[6:0], link.sda};
		end
	end

	// Byte-done toggle; reset only asserts, the toggle moves on the eighth
	// edge so a late release cannot disturb it.
	always_ff @(posedge link.scl or negedge nrst) begin
		if (!nrst) begin
			spi_tgl <= 1'b0;
		end else if (spi_cnt == 3'h7) begin
			spi_tgl <= ~spi_tgl;
		end
	end

	// Two-stage synchronisers for pins and the toggle; no reset, so the
	// strap can be sampled while reset is held.
	always_ff @(posedge clk) begin
		pin_s1 <= {link.scl, link.sda, link.cs_strap, spi_tgl}; // R13
		pin_s2 <= pin_s1;
		{scl_p, sda_p, cs_p, tgl_p} <= pin_s2;
	end

	// Edge and condition decoding on synchronised pins.
	wire scl_s     = pin_s2[3];
	wire sda_s     = pin_s2[2];
	wire cs_s      = pin_s2[1];
	wire tgl_s     = pin_s2[0];
	wire start_ev  = scl_s & scl_p & sda_p & ~sda_s; // R1
	wire stop_ev   = scl_s & scl_p & ~sda_p & sda_s; // R2
	wire scl_rise  = scl_s & ~scl_p;
	wire scl_fall  = ~scl_s & scl_p;
	wire cs_fall   = cs_p & ~cs_s;
	wire spi_ev    = tgl_s ^ tgl_p;
	wire byte_done = scl_fall && (cnt == ctrl_port_pkg::BYTE_LAST_BIT);
	wire addr_hit  = (sh[7:3] == ctrl_port_pkg::CHIP_ADDR_HI) && (sh[1] == strap); // R4
	wire spi_hit   = (spi_byte[7:1] == ctrl_port_pkg::SPI_CHIP_ADDR) && !spi_byte[0]; // R18
	wire [6:0] next_addr = step_flag ? reg_addr + 7'h01 : reg_addr; // R8 R9

	// Strap capture in reset and the one-way mode switch.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			strap    <= cs_s; // R5
			spi_mode <= 1'b0;
		end else if (cs_fall) begin
			spi_mode <= 1'b1; // R15
		end
	end

	// Data line is open drain: only the enable moves.
	always_ff @(posedge clk) begin
		link.dev_sda_out <= 1'b0;
	end

	// Transfer engine for both modes, pointer and register writes.
	always_ff @(posedge clk) begin
		reg_we <= 1'b0;
		// The pointer steps one cycle after a write strobe.
		// The strobe therefore always shows the address that was written.
		if (reg_we) begin
			reg_addr <= next_addr; // R8
		end
		if (!nrst) begin
			state             <= ctrl_port_pkg::ST_IDLE;
			cnt               <= 4'h0;
			sh                <= 8'h00;
			rw                <= 1'b0;
			host_ack          <= 1'b0;
			link.dev_sda_oe_n <= 1'b1;
			reg_addr          <= 7'h00;
			step_flag         <= 1'b0;
			reg_wdata         <= 8'h00;
			spi_idx           <= 2'h0;
		end else if (spi_mode) begin
			state             <= ctrl_port_pkg::ST_IDLE;
			link.dev_sda_oe_n <= 1'b1;
			if (cs_s) begin
				spi_idx <= 2'h0;
			end else if (spi_ev) begin
				case (spi_idx)
					2'h0: begin
						spi_idx <= spi_hit ? 2'h1 : 2'h3; // R18
					end
					2'h1: begin
						{step_flag, reg_addr} <= spi_byte; // R6
						spi_idx               <= 2'h2;
					end
					2'h2: begin
						reg_wdata <= spi_byte;
						reg_we    <= 1'b1; // R8
					end
					default: begin
					end
				endcase
			end
		end else if (start_ev) begin
			state             <= ctrl_port_pkg::ST_ADDR; // R1
			cnt               <= 4'h0;
			link.dev_sda_oe_n <= 1'b1;
		end else if (stop_ev) begin
			state             <= ctrl_port_pkg::ST_IDLE; // R2 R12
			link.dev_sda_oe_n <= 1'b1;
		end else begin
			case (state)
				ctrl_port_pkg::ST_ADDR, ctrl_port_pkg::ST_PTR, ctrl_port_pkg::ST_WR: begin
					if (scl_rise) begin
						sh  <= {sh[6:0], sda_s};
						cnt <= cnt + 4'h1;
					end else if (byte_done) begin
						cnt               <= 4'h0;
						link.dev_sda_oe_n <= 1'b0; // R10
						if (state == ctrl_port_pkg::ST_ADDR) begin
							rw <= sh[0];
							if (addr_hit) begin
								state <= ctrl_port_pkg::ST_ACK_ADDR;
							end else begin
								state             <= ctrl_port_pkg::ST_IDLE; // R19
								link.dev_sda_oe_n <= 1'b1;
							end
						end else if (state == ctrl_port_pkg::ST_PTR) begin
							{step_flag, reg_addr} <= sh; // R6 R9
							state                 <= ctrl_port_pkg::ST_ACK_PTR;
						end else begin
							reg_wdata <= sh;
							reg_we    <= 1'b1; // R8
							state     <= ctrl_port_pkg::ST_ACK_WR;
						end
					end
				end
				ctrl_port_pkg::ST_ACK_ADDR: begin
					if (scl_fall) begin
						cnt <= 4'h0;
						if (rw) begin
							state             <= ctrl_port_pkg::ST_RD; // R7
							sh                <= reg_rdata;
							link.dev_sda_oe_n <= reg_rdata[7];
						end else begin
							state             <= ctrl_port_pkg::ST_PTR;
							link.dev_sda_oe_n <= 1'b1;
						end
					end
				end
				ctrl_port_pkg::ST_ACK_PTR, ctrl_port_pkg::ST_ACK_WR: begin
					if (scl_fall) begin
						state             <= ctrl_port_pkg::ST_WR;
						link.dev_sda_oe_n <= 1'b1;
					end
				end
				ctrl_port_pkg::ST_RD: begin
					if (scl_fall) begin
						if (cnt == 4'h7) begin
							state             <= ctrl_port_pkg::ST_ACK_RD;
							link.dev_sda_oe_n <= 1'b1;
						end else begin
							sh                <= {sh[6:0], 1'b0};
							link.dev_sda_oe_n <= sh[6];
							cnt               <= cnt + 4'h1;
						end
					end
				end
				ctrl_port_pkg::ST_ACK_RD: begin
					if (scl_rise) begin
						host_ack <= ~sda_s; // R10
						reg_addr <= next_addr; // R8
					end else if (scl_fall) begin
						cnt <= 4'h0;
						if (host_ack) begin
							state             <= ctrl_port_pkg::ST_RD;
							sh                <= reg_rdata;
							link.dev_sda_oe_n <= reg_rdata[7];
						end else begin
							state <= ctrl_port_pkg::ST_IDLE;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

endmodule : codec_control_port
`default_nettype wire

// ### src/codec_port_host.sv
// Host end of the codec control link: two-wire master for one command.
// Assumes commands come from logic on clk; makes the link clock itself by
// dividing clk, and drives the strap level on the shared select pin.
`timescale 1ns/100ps
`default_nettype none
module codec_port_host #(
	parameter int unsigned QUARTER = ctrl_port_pkg::QUARTER_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	ctrl_link_if.host       link,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_read,
	input  wire logic [7:0] cmd_ptr,
	input  wire logic [7:0] cmd_wdata,
	input  wire logic       strap_level,
	output logic            busy,
	output logic            done,
	output logic      [7:0] rdata,
	output logic            nack
);

	ctrl_port_pkg::host_op_t op;
	logic [15:0] qcnt;
	logic [1:0]  phase;
	logic [3:0]  idx;
	logic [3:0]  bitn;
	logic [7:0]  sh;
	logic        rd;
	logic        abort;
	logic [7:0]  ptr;
	logic [7:0]  wd;
	logic        sda_s1;
	logic        sda_s;

	// Operation sequence; a read is preceded by a pointer-only write. R11
	always_comb begin
		case ({rd, idx})
			5'h00, 5'h10, 5'h14: op = ctrl_port_pkg::OP_START;
			5'h01, 5'h02, 5'h03: op = ctrl_port_pkg::OP_TX;
			5'h11, 5'h12, 5'h15: op = ctrl_port_pkg::OP_TX;
			5'h16:               op = ctrl_port_pkg::OP_RX;
			5'h04, 5'h13, 5'h17: op = ctrl_port_pkg::OP_STOP;
			default:             op = ctrl_port_pkg::OP_END;
		endcase
	end

	// Byte to send and decoded step conditions.
	wire [7:0] addr_w  = {ctrl_port_pkg::CHIP_ADDR_HI, ctrl_port_pkg::CHIP_ADDR_A1,
	                      strap_level, 1'b0}; // R3
	wire [7:0] tx_byte = (idx == 4'h1) ? addr_w :
	                     (idx == 4'h2) ? ptr :
	                     (idx == 4'h3) ? wd : {addr_w[7:1], 1'b1};
	wire       tick    = (qcnt == 16'(QUARTER - 1));
	wire       last    = (bitn == ctrl_port_pkg::BYTE_LAST_BIT);
	wire [3:0] stop_ix = !rd ? 4'h4 : (idx < 4'h4) ? 4'h3 : 4'h7;

	// Data line synchroniser and strap pin drive.
	always_ff @(posedge clk) begin
		sda_s1             <= link.sda;
		sda_s              <= sda_s1;
		link.cs_strap      <= strap_level;
		link.host_sda_out  <= 1'b0;
	end

	// Quarter-bit divider, running only while busy.
	always_ff @(posedge clk) begin
		if (!nrst || !busy || tick) begin
			qcnt <= 16'h0000;
		end else begin
			qcnt <= qcnt + 16'h0001;
		end
	end

	// Bus sequencer; lines stay still between commands. R14
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!nrst) begin
			busy               <= 1'b0;
			link.scl           <= 1'b1;
			link.host_sda_oe_n <= 1'b1;
			{phase, idx, bitn} <= 10'h000;
			{sh, ptr, wd}      <= 24'h000000;
			{rd, abort, nack}  <= 3'h0;
			rdata              <= 8'h00;
		end else if (!busy) begin
			if (cmd_valid) begin
				busy  <= 1'b1;
				rd    <= cmd_read;
				ptr   <= cmd_ptr;
				wd    <= cmd_wdata;
				abort <= 1'b0;
				nack  <= 1'b0;
				idx   <= 4'h0;
				phase <= 2'h0;
				bitn  <= 4'h0;
			end
		end else if (op == ctrl_port_pkg::OP_END) begin
			busy <= 1'b0;
			done <= 1'b1;
		end else if (tick) begin
			phase <= phase + 2'h1;
			case (op)
				ctrl_port_pkg::OP_START: begin
					if (phase == 2'h0) begin
						link.host_sda_oe_n <= 1'b1;
						link.scl           <= 1'b1;
					end else if (phase == 2'h2) begin
						link.host_sda_oe_n <= 1'b0; // R1
					end else if (phase == 2'h3) begin
						link.scl <= 1'b0;
						idx      <= idx + 4'h1;
					end
				end
				ctrl_port_pkg::OP_STOP: begin
					if (phase == 2'h0) begin
						link.host_sda_oe_n <= 1'b0;
					end else if (phase == 2'h1) begin
						link.scl <= 1'b1;
					end else if (phase == 2'h2) begin
						link.host_sda_oe_n <= 1'b1; // R2
					end else begin
						idx <= abort ? 4'hF : idx + 4'h1;
					end
				end
				default: begin
					if (phase == 2'h0) begin
						if (bitn == 4'h0 && op == ctrl_port_pkg::OP_TX) begin
							sh                 <= tx_byte;
							link.host_sda_oe_n <= tx_byte[7];
						end else if (last && op == ctrl_port_pkg::OP_TX) begin
							link.host_sda_oe_n <= 1'b1;
						end else if (op == ctrl_port_pkg::OP_TX) begin
							link.host_sda_oe_n <= sh[7];
						end else begin
							// Single-byte read: release, so the ninth bit is a no-acknowledge.
							link.host_sda_oe_n <= 1'b1; // R10
						end
					end else if (phase == 2'h1) begin
						link.scl <= 1'b1;
					end else if (phase == 2'h2) begin
						if (op == ctrl_port_pkg::OP_TX && last) begin
							nack  <= sda_s; // R10
							abort <= sda_s;
						end else if (op == ctrl_port_pkg::OP_RX && !last) begin
							sh <= {sh[6:0], sda_s};
						end
					end else begin
						link.scl <= 1'b0;
						bitn     <= last ? 4'h0 : bitn + 4'h1;
						if (op == ctrl_port_pkg::OP_TX) begin
							sh <= {sh[6:0], 1'b0};
						end
						if (last && op == ctrl_port_pkg::OP_RX) begin
							rdata <= sh;
						end
						if (last) begin
							idx <= abort ? stop_ix : idx + 4'h1;
						end
					end
				end
			endcase
		end
	end

endmodule : codec_port_host
`default_nettype wire

// ### testbench/ctrl_port_assertions.sv
// Concurrent checks on the two-wire link between the host and the codec port.
// Assumes plain link signals sampled on the 40 MHz clk, sync active-low nrst.
`timescale 1ns/100ps
`default_nettype none
module ctrl_port_assertions (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl,
	input wire logic cs_strap,
	input wire logic host_sda_out,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe_n,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       cs_q;
	logic       strap_q;
	logic       spi_seen;
	logic [3:0] cnt;
	logic [7:0] addr;

	// Bus conditions and address decode rebuilt from the wire.
	wire start_c = scl & scl_q & sda_q & ~sda;
	wire stop_c  = scl & scl_q & ~sda_q & sda;
	wire rise_c  = scl & ~scl_q;
	wire match   = (addr[7:3] == 5'h13) && (addr[1] == strap_q);
	wire addr_in = (cnt == 4'h8) || (cnt == 4'h9);

	// Collect the address byte after each start; remember strap and select fall.
	always_ff @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		cs_q  <= cs_strap;
		if (!nrst) begin
			strap_q  <= cs_strap;
			spi_seen <= 1'b0;
			cnt      <= 4'hF;
			addr     <= 8'h00;
		end else begin
			if (cs_q && !cs_strap)
				spi_seen <= 1'b1;
			if (start_c)
				cnt <= 4'h0;
			else if (rise_c && cnt < 4'h9)
				cnt <= cnt + 4'h1;
			if (rise_c && cnt < 4'h8)
				addr <= {addr[6:0], sda};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_open_drain; !dev_sda_oe_n |-> !dev_sda_out; endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("device drove the data line high");
	property p_change_low; $changed(dev_sda_oe_n) |-> !scl; endproperty
	a_change_low: assert property (p_change_low)
		else $error("device changed data while clock high");
	property p_start_quiet; start_c |=> dev_sda_oe_n [*8]; endproperty
	a_start_quiet: assert property (p_start_quiet)
		else $error("device pulled data right after start");
	property p_stop_quiet; stop_c |=> dev_sda_oe_n [*8]; endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("device pulled data right after stop");
	property p_ack_stand; $fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*8]; endproperty
	a_ack_stand: assert property (p_ack_stand)
		else $error("device bit not held");
	property p_spi_quiet; spi_seen |-> dev_sda_oe_n; endproperty
	a_spi_quiet: assert property (p_spi_quiet)
		else $error("device drove data in serial-peripheral mode");
	property p_mismatch; addr_in && !match |-> dev_sda_oe_n; endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("device answered a foreign address");
	property p_match_ack;
		(cnt == 4'h8) && match && !spi_seen && $fell(scl) |-> ##[2:6] !dev_sda_oe_n;
	endproperty
	a_match_ack: assert property (p_match_ack)
		else $error("device did not acknowledge its address");
	property p_host_drain; !host_sda_oe_n |-> !host_sda_out; endproperty
	a_host_drain: assert property (p_host_drain)
		else $error("host drove the data line high");
	property p_host_change; $changed(host_sda_oe_n) && scl |-> start_c || stop_c; endproperty
	a_host_change: assert property (p_host_change)
		else $error("host changed data while clock high outside start or stop");
endmodule : ctrl_port_assertions
`default_nettype wire

// ### testbench/codec_control_port_tb.sv
// Testbench: host and codec port joined on one link, plus a second port
// driven by hand in serial-peripheral mode. Assumes only clk is made here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
	end \
end
module codec_control_port_tb;
	logic        clk;
	logic        nrst;
	logic        cmd_valid;
	logic        cmd_read;
	logic        strap_level;
	logic [7:0]  cmd_ptr;
	logic [7:0]  cmd_wdata;
	logic        busy;
	logic        done;
	logic        nack;
	logic [7:0]  rdata;
	logic [7:0]  rd_a;
	logic [7:0]  wd_a;
	logic [7:0]  wd_b;
	logic [6:0]  addr_a;
	logic [6:0]  addr_b;
	logic        we_a;
	logic        we_b;
	logic        spi_a;
	logic        spi_b;
	logic        strap_a;
	logic        strap_b;
	logic [7:0]  regs [128];
	logic [14:0] log_b [$];
	logic [14:0] exp_b [4] = '{15'h0511, 15'h0622, 15'h0577, 15'h0588};
	int          n_fail;
	int          n_compared;
	int          n_we;

	ctrl_link_if link_a ();
	ctrl_link_if link_b ();

	codec_control_port u_codec_control_port (.clk(clk), .nrst(nrst), .link(link_a),
		.reg_rdata(rd_a), .reg_addr(addr_a), .reg_wdata(wd_a), .reg_we(we_a),
		.spi_mode(spi_a), .strap(strap_a));
	codec_port_host #(.QUARTER(8)) u_codec_port_host (.clk(clk), .nrst(nrst), .link(link_a),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr),
		.cmd_wdata(cmd_wdata), .strap_level(strap_level), .busy(busy), .done(done),
		.rdata(rdata), .nack(nack));
	codec_control_port u_codec_control_port_b (.clk(clk), .nrst(nrst), .link(link_b),
		.reg_rdata(8'h00), .reg_addr(addr_b), .reg_wdata(wd_b), .reg_we(we_b),
		.spi_mode(spi_b), .strap(strap_b));
	ctrl_port_assertions u_ctrl_port_assertions (.clk(clk), .nrst(nrst), .scl(link_a.scl),
		.cs_strap(link_a.cs_strap), .host_sda_out(link_a.host_sda_out),
		.host_sda_oe_n(link_a.host_sda_oe_n), .dev_sda_out(link_a.dev_sda_out),
		.dev_sda_oe_n(link_a.dev_sda_oe_n), .sda(link_a.sda));

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;

	// Register file behind the first port and a write log for the second.
	assign rd_a = regs[addr_a];
	always @(posedge clk) begin
		if (we_a) begin
			regs[addr_a] <= wd_a;
			n_we <= n_we + 1;
		end
		if (we_b)
			log_b.push_back({addr_b, wd_b});
	end

	// Prints the counts and the verdict, then ends the run.
	task wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// Hands one command to the host and waits a bounded time for done.
	task host_cmd(input logic rd, input logic [7:0] ptr, input logic [7:0] wd);
		int i;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_read  = rd;
		cmd_ptr   = ptr;
		cmd_wdata = wd;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 5000 && done !== 1'b1; i++)
			@(negedge clk);
		if (i == 5000) begin
			n_fail++;
			wrap_up;
		end
	endtask : host_cmd

	// One serial-peripheral byte, MSB first, clock idling high.
	task spi_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			link_b.scl = 1'b0;
			link_b.host_sda_oe_n = b[i];
			#62.5;
			link_b.scl = 1'b1;
			#62.5;
		end
	endtask : spi_byte

	// One framed access of four bytes; the data line is released afterwards.
	task spi_frame(input logic [31:0] bytes);
		link_b.cs_strap = 1'b0;
		#62.5;
		for (int k = 3; k >= 0; k--)
			spi_byte(bytes[8*k +: 8]);
		#62.5;
		link_b.cs_strap = 1'b1;
		link_b.host_sda_oe_n = 1'b1;
		#500;
	endtask : spi_frame

	task t_write;
		host_cmd(1'b0, 8'h05, 8'hA5);
		`CHK("write nack", 1'b0, nack)
		`CHK("write data", 8'hA5, regs[5])
		`CHK("fixed pointer", 7'h05, addr_a)
		`CHK("idle clock", 1'b1, link_a.scl)
		`CHK("idle data", 1'b1, link_a.sda)
		`CHK("idle host", 1'b0, busy)
	endtask : t_write

	task t_step;
		host_cmd(1'b0, 8'h85, 8'h3C);
		`CHK("step data", 8'h3C, regs[5])
		`CHK("stepped pointer", 7'h06, addr_a)
	endtask : t_step

	task t_read;
		host_cmd(1'b1, 8'h05, 8'h00);
		`CHK("read data", 8'h3C, rdata)
		`CHK("read nack", 1'b0, nack)
		`CHK("preamble writes", 2, n_we)
		`CHK("preamble pointer", 7'h05, addr_a)
		host_cmd(1'b1, 8'h85, 8'h00);
		`CHK("step read data", 8'h3C, rdata)
		`CHK("step read pointer", 7'h06, addr_a)
	endtask : t_read

	task t_mismatch;
		strap_level = 1'b1;
		repeat (4) @(negedge clk);
		host_cmd(1'b0, 8'h07, 8'h99);
		`CHK("foreign nack", 1'b1, nack)
		`CHK("foreign writes", 2, n_we)
		`CHK("latched strap", 1'b0, strap_a)
	endtask : t_mismatch

	task t_spi_select;
		strap_level = 1'b0;
		repeat (10) @(negedge clk);
		`CHK("select fall", 1'b1, spi_a)
		host_cmd(1'b0, 8'h05, 8'h77);
		`CHK("two-wire ignored", 1'b1, nack)
		`CHK("no write", 8'h3C, regs[5])
	endtask : t_spi_select

	task t_spi;
		spi_frame(32'h9E851122);
		spi_frame(32'h9A053344);
		spi_frame(32'h9F055566);
		spi_frame(32'h9E057788);
		`CHK("spi mode", 1'b1, spi_b)
		`CHK("spi writes", 4, log_b.size())
		for (int i = 0; i < 4 && i < log_b.size(); i++)
			`CHK("spi write", exp_b[i], log_b[i])
		`CHK("spi line", 1'b1, link_b.dev_sda_oe_n)
	endtask : t_spi

	// Reset, then the scenarios in order.
	initial begin
		clk         = 1'b0;
		nrst        = 1'b0;
		cmd_valid   = 1'b0;
		cmd_read    = 1'b0;
		cmd_ptr     = 8'h00;
		cmd_wdata   = 8'h00;
		strap_level = 1'b0;
		link_b.scl           = 1'b1;
		link_b.cs_strap      = 1'b1;
		link_b.host_sda_out  = 1'b0;
		link_b.host_sda_oe_n = 1'b1;
		n_fail     = 0;
		n_compared = 0;
		n_we       = 0;
		for (int i = 0; i < 128; i++)
			regs[i] = 8'h00;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		`CHK("strap low", 1'b0, strap_a)
		`CHK("strap high", 1'b1, strap_b)
		`CHK("mode at reset", 1'b0, spi_a)
		t_write;
		t_step;
		t_read;
		t_mismatch;
		t_spi_select;
		t_spi;
		wrap_up;
	end
endmodule : codec_control_port_tb
`default_nettype wire
